// ==== sim/rmd_io_dev.sv ====
/*
  Interrupting I/O device model: issues one-cycle request pulses.
  Assumes the testbench calls pulse from its main sequence.
*/
module rmd_io_dev (
  input wire logic pclk,
  output logic irq_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial irq_req = 1'b0;
  // Raised and dropped just after rising edges, never in between
  task automatic pulse();
    @(posedge pclk);
    irq_req <= 1'b1;
    @(posedge pclk);
    irq_req <= 1'b0;
  endtask
endmodule // rmd_io_dev

// ==== sim/rmd_top_asserts.sv ====
/*
  Port checker for rmd_top, bound into every instance.
  Assumes APB with zero wait states and one-cycle request answers.
*/
`include "rmd_regs.svh"
module rmd_top_asserts
  import rmd_pkg::*;
#(
  parameter int DEST_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_req,
  input wire logic dlv_valid,
  input wire logic [DEST_W-1:0] dlv_dest,
  input wire logic dlv_logical,
  input wire logic dlv_hint,
  input wire logic req_blocked,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase, then a single answer cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_ready_next: assert property (s_setup |=> s_answer)
    else $error("pready not a one-cycle answer");
  a_req_answer: assert property (irq_req |=> (dlv_valid ^ req_blocked))
    else $error("request got no single answer");
  a_blocked_excl: assert property (req_blocked |-> !dlv_valid)
    else $error("blocked request delivered");
  a_no_spurious: assert property (!irq_req |=> !dlv_valid && !req_blocked)
    else $error("answer without request");
  a_dest_hold: assert property ($changed(dlv_dest) |-> dlv_valid)
    else $error("destination moved without delivery");
  a_mode_hold: assert property ($changed(dlv_logical) || $changed(dlv_hint) |-> dlv_valid)
    else $error("mode bits moved without delivery");
  a_hint_onehot: assert property (dlv_valid && dlv_hint |-> $onehot(dlv_dest))
    else $error("hinted delivery not to one processor");
  a_rsvd_zero: assert property (pready && !pwrite && !pslverr
    && paddr[11:0] == `RMD_OFF_ENTRY_LO |-> prdata[31:4] == 28'h0)
    else $error("reserved entry bits read nonzero");
  // Interrupt rises only after an event pulse or a register write
  a_irq_cause: assert property ($rose(irq) |-> $past(dlv_valid) || $past(req_blocked)
    || ($past(pready, 2) && $past(pwrite, 2)))
    else $error("interrupt rose without a cause");
endmodule // rmd_top_asserts

bind rmd_top rmd_top_asserts #(.DEST_W(DEST_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
  .dlv_valid(dlv_valid), .dlv_dest(dlv_dest), .dlv_logical(dlv_logical),
  .dlv_hint(dlv_hint), .req_blocked(req_blocked), .irq(irq));

// ==== sim/tb_remap_entry_decode_and_reg_access.sv ====
/*
  Self-checking bench for rmd_top over APB and the request port.
  Assumes the checker is bound and rmd_io_dev is compiled.
*/
`include "rmd_regs.svh"
module tb_remap_entry_decode_and_reg_access;
  import rmd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Stimulus and harness
  // ----------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, dlv_dest, rv, first;
  logic [31:0] base = `RMD_REGION_RST, cnt;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, irq_req, dlv_valid, dlv_logical, dlv_hint, req_blocked, irq, ev;
  int errors = 0, samples_checked = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  rmd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .dlv_valid(dlv_valid),
    .dlv_dest(dlv_dest), .dlv_logical(dlv_logical), .dlv_hint(dlv_hint),
    .req_blocked(req_blocked), .irq(irq));
  rmd_io_dev dev (.pclk(pclk), .irq_req(irq_req));
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; the answer is awaited, never assumed
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] o, input logic [31:0] d);
    apb(1'b1, base + o, d, 4'hf);
  endtask
  task rd(input logic [11:0] o);
    apb(1'b0, base + o, 32'h0, 4'hf);
  endtask
  // Entry goes in low word first, high word commits both
  task ent(input logic [3:0] c, input logic [31:0] dst);
    wr(`RMD_OFF_ENTRY_LO, {28'h0, c});
    wr(`RMD_OFF_ENTRY_HI, dst);
  endtask
  task req();
    dev.pulse();
    #1;
  endtask
  task report_and_stop();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_window();
    rd(`RMD_OFF_VERSION);
    chk(rv, `RMD_VERSION_VAL);
    rd(12'h004);
    chk(ev, 1'b1);
    apb(1'b0, base + 32'h1000, 32'h0, 4'hf);
    chk(ev, 1'b1);
    apb(1'b1, base + `RMD_OFF_INT_EN, 32'h7, 4'h3);
    chk(ev, 1'b1);
    rd(`RMD_OFF_INT_EN);
    chk(rv, 32'h0);
  endtask
  // Relocation works until locked, then the base freezes
  task t_lock();
    wr(`RMD_OFF_REGION, 32'h0002_0000);
    base = 32'h0002_0000;
    rd(`RMD_OFF_REGION);
    chk(rv, 32'h0002_0000);
    wr(`RMD_OFF_LOCK, 32'h1);
    wr(`RMD_OFF_REGION, 32'h0003_0000);
    rd(`RMD_OFF_REGION);
    chk(rv, 32'h0002_0000);
  endtask
  task t_split();
    wr(`RMD_OFF_ENTRY_LO, 32'h1);
    rd(`RMD_OFF_ENTRY_LO);
    chk(rv, 32'h0);
    wr(`RMD_OFF_ENTRY_HI, 32'h42);
    rd(`RMD_OFF_ENTRY_LO);
    chk(rv, 32'h1);
  endtask
  task t_deliver();
    ent(4'h5, 32'h42);
    req();
    chk({dlv_valid, req_blocked, dlv_hint, dlv_logical}, 4'h9);
    chk(dlv_dest, 32'h42);
    ent(4'h1, 32'h17);
    req();
    chk(dlv_logical, 1'b0);
    rd(`RMD_OFF_LAST_DEST);
    chk(rv, 32'h17);
    rd(`RMD_OFF_ENTRY_HI);
    chk(rv, 32'h17);
  endtask
  // Hinted entry spreads over the named processors only
  task t_hint();
    ent(4'h9, 32'h0a);
    req();
    chk(dlv_dest & 32'hffff_fff5, 32'h0);
    chk($onehot(dlv_dest), 1'b1);
    first = dlv_dest;
    req();
    chk(dlv_dest == first, 1'b0);
  endtask
  task t_block();
    wr(`RMD_OFF_INT_CLR, 32'h7);
    rd(`RMD_OFF_FAULT_CNT);
    cnt = rv;
    ent(4'hc, 32'h99);
    req();
    // Mode outputs keep the last (hinted, physical) delivery
    chk({dlv_valid, req_blocked, dlv_logical, dlv_hint}, 4'h5);
    rd(`RMD_OFF_FAULT_CNT);
    chk(rv, cnt + 1);
    rd(`RMD_OFF_STATUS);
    chk(rv, 32'h6);
    wr(`RMD_OFF_INT_CLR, 32'h7);
    ent(4'he, 32'h99);
    req();
    rd(`RMD_OFF_FAULT_CNT);
    chk(rv, cnt + 1);
    rd(`RMD_OFF_STATUS);
    chk(rv, 32'h2);
  endtask
  // Raise, mask and clear the level interrupt
  task t_irq();
    wr(`RMD_OFF_INT_CLR, 32'h7);
    wr(`RMD_OFF_INT_EN, 32'h1);
    #1;
    chk(irq, 1'b0);
    ent(4'h1, 32'h5);
    req();
    @(posedge pclk);
    #1;
    chk(irq, 1'b1);
    wr(`RMD_OFF_INT_EN, 32'h0);
    @(posedge pclk);
    #1;
    chk(irq, 1'b0);
    rd(`RMD_OFF_INT_EN);
    wr(`RMD_OFF_INT_EN, rv | 32'h1);
    wr(`RMD_OFF_INT_CLR, 32'h1);
    @(posedge pclk);
    #1;
    chk(irq, 1'b0);
  endtask
  // Mid-run reset frees the lock and empties the entry
  task t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    base = `RMD_REGION_RST;
    rd(`RMD_OFF_REGION);
    chk(rv, `RMD_REGION_RST);
    wr(`RMD_OFF_REGION, 32'h0002_0000);
    base = 32'h0002_0000;
    rd(`RMD_OFF_REGION);
    chk(rv, 32'h0002_0000);
    req();
    chk({dlv_valid, req_blocked}, 2'h1);
    rd(`RMD_OFF_FAULT_CNT);
    chk(rv, 32'h1);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_window();
    t_lock();
    t_split();
    t_deliver();
    t_hint();
    t_block();
    t_irq();
    t_reset();
    report_and_stop();
  end
endmodule // tb_remap_entry_decode_and_reg_access

// ==== src/rmd_entry_decode.sv ====
/*
  Decodes the low control bits and destination of a remap entry.
  Assumes the raw entry is a stable registered value.
*/
`include "rmd_regs.svh"
module rmd_entry_decode
  import rmd_pkg::*;
(
  rmd_entry_if.dec ent
);
  // Hint and addressing select mean nothing without present
  always_comb begin
    ent.ctrl.present = ent.raw[`RMD_BIT_PRESENT];
    ent.ctrl.suppress = ent.raw[`RMD_BIT_SUPPRESS];
    ent.ctrl.logical = ent.raw[`RMD_BIT_PRESENT] & ent.raw[`RMD_BIT_DEST_SEL];
    ent.ctrl.hint = ent.raw[`RMD_BIT_PRESENT] & ent.raw[`RMD_BIT_HINT];
    ent.dest = ent.raw[63:32];
  end
endmodule // rmd_entry_decode

// ==== src/rmd_entry_if.sv ====
/*
  Carries a raw remap entry to the decoder and the decoded view back.
  Assumes both ends run on the same clock.
*/
interface rmd_entry_if;
  import rmd_pkg::*;
  logic [63:0] raw;
  rmd_ctrl_t ctrl;
  logic [31:0] dest;

  modport src (output raw, input ctrl, input dest);
  modport dec (input raw, output ctrl, output dest);
endinterface

// ==== src/rmd_pkg.sv ====
/*
  Types shared by the remap entry decode block.
  Assumes rmd_regs.svh is on the include path.
*/
package rmd_pkg;
  `include "rmd_regs.svh"

  // Quadword split tracking
  typedef enum logic [0:0] {
    RMD_QW_IDLE = 1'b0,
    RMD_QW_LOW_HELD = 1'b1
  } rmd_qw_state_t;

  // Decoded entry control bits
  typedef struct packed {
    logic present;
    logic suppress;
    logic logical;
    logic hint;
  } rmd_ctrl_t;
endpackage

// ==== src/rmd_regs.svh ====
/*
  Register offsets, field positions, reset values and widths of the remap
  entry decode block. Assumes inclusion by bare name from the package.
*/
`ifndef RMD_REGS_SVH
`define RMD_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets inside the 4KB window
// ----------------------------------------------------------------
`define RMD_OFF_VERSION 12'h000
`define RMD_OFF_REGION 12'h010
`define RMD_OFF_LOCK 12'h014
`define RMD_OFF_ENTRY_LO 12'h020
`define RMD_OFF_ENTRY_HI 12'h024
`define RMD_OFF_STATUS 12'h030
`define RMD_OFF_INT_EN 12'h034
`define RMD_OFF_INT_CLR 12'h038
`define RMD_OFF_FAULT_CNT 12'h03c
`define RMD_OFF_LAST_DEST 12'h040

// ----------------------------------------------------------------
// Entry control field positions (low doubleword)
// ----------------------------------------------------------------
`define RMD_BIT_PRESENT 0
`define RMD_BIT_SUPPRESS 1
`define RMD_BIT_DEST_SEL 2
`define RMD_BIT_HINT 3
`define RMD_ENTRY_LO_MASK 32'h0000_000f

// ----------------------------------------------------------------
// Status / interrupt bit positions
// ----------------------------------------------------------------
`define RMD_ST_DELIVERED 0
`define RMD_ST_BLOCKED 1
`define RMD_ST_FAULT 2
`define RMD_ST_WIDTH 3

// ----------------------------------------------------------------
// Window, version and reset values
// ----------------------------------------------------------------
`define RMD_WIN_BITS 12
`define RMD_VERSION_VAL 32'h0000_0010
`define RMD_REGION_RST 32'h0001_0000
`define RMD_STRB_FULL 4'hf

`endif

// ==== src/rmd_top.sv ====
/*
  APB register window and request path of the interrupt remap entry
  decoder: one programmable entry, delivery, blocking and fault counting.
  Assumes an APB master on pclk and request pulses synchronous to pclk.
*/
// The register offsets and the APB interface to the registers were decided locally.
`include "rmd_regs.svh"

//
// Summary of operation
// - Hint clear: deliver to named processor
// - Hint set: hardware picks one of N
// - Hint and mode ignored unless present
// - Mode bit: physical zero, logical one
// - Suppress bit stops fault recording and reporting
// - Suppress evaluated whatever present says
// - Not present: block every request
// - Present: process per entry fields
// - Register window on 4KB boundary
// - Relocatable window has secure lock
// - Split quadword: low then high, atomic
// - Reserved fields read-only, read zero
module rmd_top
  import rmd_pkg::*;
#(
  parameter logic [31:0] VERSION = `RMD_VERSION_VAL, // Arbitrary value
  parameter logic [31:0] REGION_RST = `RMD_REGION_RST,
  parameter int DEST_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_req,
  output logic dlv_valid,
  output logic [DEST_W-1:0] dlv_dest,
  output logic dlv_logical,
  output logic dlv_hint,
  output logic req_blocked,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Next set bit after ptr, circular; ptr itself if mask empty
  // Limitation: the pointer is five bits, so DEST_W must stay 32
  // or the scan indexes past the top of the mask
  function automatic logic [4:0] pick_next(
    input logic [DEST_W-1:0] mask,
    input logic [4:0] ptr
  );
    logic [4:0] idx;
    logic found;
    pick_next = ptr;
    found = 1'b0;
    for (int i = 1; i <= DEST_W; i++) begin
      idx = 5'(int'(ptr) + i);
      if (!found && mask[idx]) begin
        pick_next = idx;
        found = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] region_reg;
  logic lock_reg;
  logic [31:0] stage_lo_reg;
  logic [63:0] entry_reg;
  rmd_qw_state_t qw_reg;
  logic [`RMD_ST_WIDTH-1:0] status_reg;
  logic [`RMD_ST_WIDTH-1:0] int_en_reg;
  logic [31:0] fault_cnt_reg;
  logic [4:0] rr_ptr_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic dlv_valid_reg;
  logic [DEST_W-1:0] dlv_dest_reg;
  logic dlv_logical_reg;
  logic dlv_hint_reg;
  logic req_blocked_reg;
  logic irq_reg;

  logic [31:0] rdata_next;
  logic hit;
  logic [11:0] off;
  logic setup;
  logic acc;
  logic wr;
  logic rd_ok;
  logic wr_ok;
  logic full_strb;
  logic [`RMD_ST_WIDTH-1:0] ev;
  logic [`RMD_ST_WIDTH-1:0] clr;
  logic [4:0] rr_pick;
  logic deliver;
  logic fault;

  // ----------------------------------------------------------------
  // Entry decode
  // ----------------------------------------------------------------
  rmd_entry_if ent ();

  assign ent.raw = entry_reg;

  rmd_entry_decode u_dec (
    .ent(ent)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Window hit compares only the page bits: base is 4KB aligned
  assign hit = paddr[31:`RMD_WIN_BITS] == region_reg[31:`RMD_WIN_BITS];
  assign off = paddr[`RMD_WIN_BITS-1:0];
  assign setup = psel & ~penable & ~pready_reg;
  assign acc = psel & penable & pready_reg;
  assign wr = acc & pwrite & wr_ok;
  assign full_strb = pstrb == `RMD_STRB_FULL;

  // Read mux; reserved bits and write-only words read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    rd_ok = hit;
    case (off)
      `RMD_OFF_VERSION: rdata_next = VERSION;
      `RMD_OFF_REGION: rdata_next = region_reg;
      `RMD_OFF_LOCK: rdata_next = {31'h0000_0000, lock_reg};
      `RMD_OFF_ENTRY_LO: rdata_next = entry_reg[31:0] & `RMD_ENTRY_LO_MASK;
      `RMD_OFF_ENTRY_HI: rdata_next = entry_reg[63:32];
      `RMD_OFF_STATUS: rdata_next = {29'h0000_0000, status_reg};
      `RMD_OFF_INT_EN: rdata_next = {29'h0000_0000, int_en_reg};
      `RMD_OFF_INT_CLR: rdata_next = 32'h0000_0000;
      `RMD_OFF_FAULT_CNT: rdata_next = fault_cnt_reg;
      `RMD_OFF_LAST_DEST: rdata_next = 32'(dlv_dest_reg);
      default: rd_ok = 1'b0;
    endcase
  end

  // Writable offsets; partial strobes are refused so that
  // a sub-dword write can never tear a field
  // Only these words take writes; everything else is read-only
  always_comb begin
    wr_ok = 1'b0;
    case (off)
      `RMD_OFF_REGION,
      `RMD_OFF_LOCK,
      `RMD_OFF_ENTRY_LO,
      `RMD_OFF_ENTRY_HI,
      `RMD_OFF_INT_EN,
      `RMD_OFF_INT_CLR: wr_ok = hit & full_strb;
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // APB response: one wait-free access, all outputs registered
  // ----------------------------------------------------------------

  // Ready rises for the access cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
    end
  end

  // Read data and error captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      pslverr_reg <= pwrite ? ~wr_ok : ~rd_ok;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Region base and lock
  // ----------------------------------------------------------------

  // Lock is set-once until reset; then the base is frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      region_reg <= REGION_RST;
      lock_reg <= 1'b0;
    end else if (wr) begin
      if (off == `RMD_OFF_REGION && !lock_reg) begin
        region_reg <= {pwdata[31:`RMD_WIN_BITS], 12'h000};
      end
      if (off == `RMD_OFF_LOCK && pwdata[0]) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Entry write: quadword split held until the high half lands
  // ----------------------------------------------------------------

  // Low half is staged; the live entry changes only on the high
  // write, so requests never see half an entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_lo_reg <= 32'h0000_0000;
      entry_reg <= 64'h0000_0000_0000_0000;
      qw_reg <= RMD_QW_IDLE;
    end else if (wr) begin
      case (off)
        `RMD_OFF_ENTRY_LO: begin
          stage_lo_reg <= pwdata & `RMD_ENTRY_LO_MASK;
          qw_reg <= RMD_QW_LOW_HELD;
        end
        `RMD_OFF_ENTRY_HI: begin
          entry_reg[63:32] <= pwdata;
          if (qw_reg == RMD_QW_LOW_HELD) begin
            entry_reg[31:0] <= stage_lo_reg;
          end
          qw_reg <= RMD_QW_IDLE;
        end
        default: qw_reg <= qw_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request path
  // ----------------------------------------------------------------

  // Present passes, absent blocks; suppress gates faults only
  assign deliver = irq_req & ent.ctrl.present;
  assign fault = irq_req & ~ent.ctrl.present & ~ent.ctrl.suppress;
  assign rr_pick = pick_next(ent.dest[DEST_W-1:0], rr_ptr_reg);

  // Round-robin pointer steps only on hinted deliveries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_ptr_reg <= 5'h00;
    end else if (deliver && ent.ctrl.hint) begin
      rr_ptr_reg <= rr_pick;
    end
  end

  // Delivery outputs, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlv_valid_reg <= 1'b0;
      dlv_dest_reg <= '0;
      dlv_logical_reg <= 1'b0;
      dlv_hint_reg <= 1'b0;
      req_blocked_reg <= 1'b0;
    end else begin
      dlv_valid_reg <= deliver;
      req_blocked_reg <= irq_req & ~ent.ctrl.present;
      if (deliver) begin
        dlv_logical_reg <= ent.ctrl.logical;
        dlv_hint_reg <= ent.ctrl.hint;
        if (ent.ctrl.hint) begin
          dlv_dest_reg <= DEST_W'(1) << rr_pick;
        end else begin
          dlv_dest_reg <= ent.dest[DEST_W-1:0];
        end
      end
    end
  end

  // Fault record counter saturates rather than wrapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_cnt_reg <= 32'h0000_0000;
    end else if (fault && fault_cnt_reg != 32'hffff_ffff) begin
      fault_cnt_reg <= fault_cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  assign ev[`RMD_ST_DELIVERED] = deliver;
  assign ev[`RMD_ST_BLOCKED] = irq_req & ~ent.ctrl.present;
  assign ev[`RMD_ST_FAULT] = fault;
  assign clr = (wr && off == `RMD_OFF_INT_CLR) ? pwdata[`RMD_ST_WIDTH-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clr) | ev;
    end
  end

  // Enable mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_reg <= '0;
    end else if (wr && off == `RMD_OFF_INT_EN) begin
      int_en_reg <= pwdata[`RMD_ST_WIDTH-1:0];
    end
  end

  // Level interrupt, registered one cycle behind status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & int_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dlv_valid = dlv_valid_reg;
  assign dlv_dest = dlv_dest_reg;
  assign dlv_logical = dlv_logical_reg;
  assign dlv_hint = dlv_hint_reg;
  assign req_blocked = req_blocked_reg;
  assign irq = irq_reg;

endmodule // rmd_top
